// File: hw/rwd_pkg.sv
/*
 * constants, field layout and types shared by the runaway watchdog.
 * assumes a single 125 MHz system clock and an axi4-lite register bus.
 */
package rwd_pkg;

   // ****************************************************************
   // bus geometry and register map
   // ****************************************************************
   localparam int          ADDR_W      = 8;       // byte address width
   localparam int          DATA_W      = 32;      // bus data width
   localparam logic [7:0]  ADDR_MODE   = 8'h00;   // watchdog_mode, rw
   localparam logic [7:0]  ADDR_CMD    = 8'h04;   // watchdog_command, wo
   localparam logic [7:0]  ADDR_STAT   = 8'h08;   // sticky events, w1c
   localparam logic [7:0]  ADDR_MASK   = 8'h0C;   // event mask
   localparam logic [7:0]  ADDR_COUNT  = 8'h10;   // counter readback, ro

   // ****************************************************************
   // watchdog_mode field positions and reset value
   // ****************************************************************
   localparam int          MODE_EN     = 7;       // wd_enable_bit
   localparam int          MODE_SEL_HI = 6;       // detect_period_sel msb
   localparam int          MODE_SEL_LO = 5;       // detect_period_sel lsb
   localparam int          MODE_I2RUN  = 3;       // light_idle_mode_run_bit
   localparam int          MODE_RSTCON = 2;       // reset_connect_bit
   localparam logic [7:0]  MODE_RESET  = 8'h80;   // enabled, period 00
   localparam logic [7:0]  MODE_MASK   = 8'hEC;   // implemented bits

   // ****************************************************************
   // command codes
   // ****************************************************************
   localparam logic [7:0]  CODE_CLEAR   = 8'h4E;  // clear the counter
   localparam logic [7:0]  CODE_DISABLE = 8'hB1;  // second step of disable

   // ****************************************************************
   // status bits, counter and forced reset timing
   // ****************************************************************
   localparam int          STAT_W       = 2;      // event count
   localparam int          STAT_RUNAWAY = 0;      // period elapsed
   localparam int          STAT_RESET   = 1;      // chip reset forced
   localparam logic [1:0]  STAT_RESET_V = 2'h0;   // status reset value
   localparam logic [1:0]  MASK_RESET_V = 2'h0;   // mask reset value
   localparam int          CNT_W        = 22;     // binary counter stages
   localparam int          TAP_BASE     = 16;     // 2^15 io clocks = 2^16 sys
   localparam int          RST_MIN_CYC  = 44;     // shortest forced reset
   localparam int          RST_MAX_CYC  = 58;     // longest forced reset
   localparam logic [5:0]  RST_CYC      = 6'd51;  // length actually used

   // forced reset sequencer states, gray along hold -> idle
   typedef enum logic [0:0] {
      RWD_RST_IDLE = 1'b0,
      RWD_RST_HOLD = 1'b1
   } rwd_rst_state_t;

endpackage

// File: hw/rwd_runaway_watchdog_timer.sv
/*
 * runaway watchdog timer: 22-stage counter, four detection taps,
 * non-maskable runaway pulse, optional forced chip reset, two-step
 * disable, axi4-lite register slave and a masked event interrupt.
 * assumes the low-power mode and bus-release inputs come from logic
 * on ref_clk, and that the chip reset request is used by a reset
 * controller elsewhere; this block never drives the reset pin itself.
 */
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
//
// Contract
// - elapsed period raises non-maskable runaway interrupt
// - reset connection forces internal reset, pin untouched
// - 22-stage counter on sysclock, four taps
// - counting starts right after reset release
// - deep idle or stop clears, halts counter
// - counter keeps running during bus release
// - light idle follows light_idle_mode run bit
// - forced reset lasts 44 to 58 cycles
// - period select resets to 00
// - enable bit resets to one
// - disable needs enable cleared then B1H
// - setting enable bit alone re-enables
// - reset connection resets to zero
// - code 4EH clears counter, counting resumes
`timescale 1ns/1ps
module rwd_runaway_watchdog_timer
   import rwd_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic [rwd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [rwd_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [rwd_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [rwd_pkg::DATA_W-1:0]   s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    deepIdleMode,
   input  wire logic                    stopMode,
   input  wire logic                    lightIdleMode,
   input  wire logic                    busReleaseAck_n,
   output logic                         runawayInterrupt,
   output logic                         chipResetReq,
   output logic                         irq
);
   import rwd_pkg::*;

   // ****************************************************************
   // decode helpers
   // ****************************************************************

   // mask of counter bits below the selected tap
   function automatic logic [CNT_W-1:0] tapMask(input logic [1:0] sel);
      logic [CNT_W-1:0] m;
      m = '0;
      unique case (sel)
         2'h0: m = CNT_W'((23'h1 << TAP_BASE) - 23'h1);
         2'h1: m = CNT_W'((23'h1 << (TAP_BASE + 2)) - 23'h1);
         2'h2: m = CNT_W'((23'h1 << (TAP_BASE + 4)) - 23'h1);
         2'h3: m = CNT_W'((23'h1 << (TAP_BASE + 6)) - 23'h1);
      endcase
      return m;
   endfunction

   // the tap fires on the cycle all bits below it are ones
   function automatic logic tapHit(input logic [CNT_W-1:0] c, input logic [1:0] sel);
      return (c & tapMask(sel)) == tapMask(sel);
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]        mode_q;        // watchdog_mode contents
   logic              disabled_q;    // two-step disable has taken effect
   logic [CNT_W-1:0]  count_q;       // binary counter
   logic              nmi_q;         // runaway pulse register
   logic [STAT_W-1:0] status_q;      // sticky events
   logic [STAT_W-1:0] mask_q;        // event mask
   rwd_rst_state_t    rstState_q;    // forced reset sequencer
   logic [5:0]        rstCnt_q;      // cycles left in forced reset
   logic              awHeld_q;      // write address captured
   logic [ADDR_W-1:0] awAddr_q;      // captured write address
   logic              wHeld_q;       // write data captured
   logic [7:0]        wByte_q;       // low byte of write data
   logic              wLane0_q;      // low byte lane enabled
   logic              bvalid_q;      // write response pending
   logic [1:0]        bresp_q;       // write response code
   logic              rvalid_q;      // read data pending
   logic [DATA_W-1:0] rdata_q;       // read data
   logic [1:0]        rresp_q;       // read response code

   logic              wrFire;        // both write halves present
   logic              wrMode;        // mode byte written
   logic              wrCmd;         // command byte written
   logic              wrStat;        // status w1c written
   logic              wrMask;        // mask written
   logic              wrMapped;      // address is a writable register
   logic              halted;        // deep idle or stop
   logic              running;       // counter advances this cycle
   logic              expire;        // selected period elapsed
   logic [1:0]        periodSel;     // detect_period_sel
   logic [STAT_W-1:0] evSet;         // events raised this cycle

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   // one write in flight: address and data are held until both are in,
   // then applied and answered; no new halves until bready drains it
   assign s_axi_awready = !awHeld_q && !bvalid_q;
   assign s_axi_wready  = !wHeld_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign wrFire        = awHeld_q && wHeld_q && !bvalid_q;
   assign wrMapped      = (awAddr_q == ADDR_MODE) || (awAddr_q == ADDR_CMD) ||
                          (awAddr_q == ADDR_STAT) || (awAddr_q == ADDR_MASK);
   // writable registers are one byte wide, so only lane 0 carries a write
   assign wrMode        = wrFire && wLane0_q && (awAddr_q == ADDR_MODE);
   assign wrCmd         = wrFire && wLane0_q && (awAddr_q == ADDR_CMD);
   assign wrStat        = wrFire && wLane0_q && (awAddr_q == ADDR_STAT);
   assign wrMask        = wrFire && wLane0_q && (awAddr_q == ADDR_MASK);

   // capture the two write halves in either order
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
         wHeld_q  <= 1'b0;
         wByte_q  <= 8'h00;
         wLane0_q <= 1'b0;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q  <= 1'b1;
            wByte_q  <= s_axi_wdata[7:0];
            wLane0_q <= s_axi_wstrb[0];
         end
      end
   end

   // write response; count readback and holes answer slverr
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
      end else if (wrFire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wrMapped ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // read data is latched when the address is taken, answered next edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= 2'h0;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= 2'h0;
         unique case (s_axi_araddr)
            ADDR_MODE:  rdata_q <= {24'h0, mode_q};
            ADDR_CMD:   rdata_q <= '0;    // command is write-only
            ADDR_STAT:  rdata_q <= {30'h0, status_q};
            ADDR_MASK:  rdata_q <= {30'h0, mask_q};
            ADDR_COUNT: rdata_q <= {10'h0, count_q};
            default: begin                // unmapped: zero and slverr
               rdata_q <= '0;
               rresp_q <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // mode register and two-step disable
   // ****************************************************************
   // reset value gives period 00, enabled, no reset connection
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_RESET;
      end else if (wrMode) begin
         mode_q <= wByte_q & MODE_MASK;
      end
   end

   // a runaway that clears the enable bit alone cannot stop the timer:
   // only the disable code, written while the bit is low, does
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         disabled_q <= 1'b0;
      end else if (wrMode && wByte_q[MODE_EN]) begin
         disabled_q <= 1'b0;
      end else if (wrCmd && wByte_q == CODE_DISABLE && !mode_q[MODE_EN]) begin
         disabled_q <= 1'b1;
      end
   end

   // ****************************************************************
   // counter
   // ****************************************************************
   assign periodSel = mode_q[MODE_SEL_HI:MODE_SEL_LO];
   assign halted    = deepIdleMode || stopMode;
   // bus release is deliberately absent from this term
   assign running   = !disabled_q && !halted &&
                      !(lightIdleMode && !mode_q[MODE_I2RUN]) &&
                      (rstState_q == RWD_RST_IDLE);
   assign expire    = running && tapHit(count_q, periodSel);

   // free counter from reset release; cleared by the clear code,
   // halted modes, disable, and while a forced reset is held
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (halted || disabled_q || rstState_q == RWD_RST_HOLD) begin
         count_q <= '0;
      end else if (wrCmd && wByte_q == CODE_CLEAR) begin
         count_q <= '0;
      end else if (running) begin
         count_q <= count_q + 22'h1;
      end
   end

   // ****************************************************************
   // runaway pulse and forced reset
   // ****************************************************************
   // the runaway pulse bypasses the mask: it is non-maskable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_q <= 1'b0;
      end else begin
         nmi_q <= expire;
      end
   end
   assign runawayInterrupt = nmi_q;

   // holds the internal reset request for a fixed count of cycles
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstState_q <= RWD_RST_IDLE;
         rstCnt_q   <= 6'h0;
      end else begin
         unique case (rstState_q)
            RWD_RST_IDLE: begin
               if (expire && mode_q[MODE_RSTCON]) begin
                  rstState_q <= RWD_RST_HOLD;
                  rstCnt_q   <= RST_CYC - 6'h1;
               end
            end
            RWD_RST_HOLD: begin
               if (rstCnt_q == 6'h0) begin
                  rstState_q <= RWD_RST_IDLE;
               end else begin
                  rstCnt_q <= rstCnt_q - 6'h1;
               end
            end
         endcase
      end
   end
   assign chipResetReq = (rstState_q == RWD_RST_HOLD);

   // ****************************************************************
   // event status, mask and interrupt
   // ****************************************************************
   assign evSet = {expire && mode_q[MODE_RSTCON], expire};

   // write one to clear; an event in the same cycle wins over the clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= STAT_RESET_V;
      end else begin
         status_q <= (status_q & ~(wrStat ? wByte_q[STAT_W-1:0] : 2'h0)) | evSet;
      end
   end

   // mask gates status onto the level interrupt
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= MASK_RESET_V;
      end else if (wrMask) begin
         mask_q <= wByte_q[STAT_W-1:0];
      end
   end
   assign irq = |(status_q & mask_q);

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_nmi_on_tap;
      running && tapHit(count_q, periodSel) |=> runawayInterrupt ##1 !runawayInterrupt;
   endproperty
   a_nmi_on_tap: assert property (p_nmi_on_tap)
      else $error("runaway pulse missing after tap hit");

   property p_reset_connect;
      expire |=> (chipResetReq == $past(mode_q[MODE_RSTCON]));
   endproperty
   a_reset_connect: assert property (p_reset_connect)
      else $error("forced reset does not follow reset connection");

   property p_count_step;
      running && !(wrCmd && wByte_q == CODE_CLEAR) |=> count_q == $past(count_q) + 22'h1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter did not advance");

   property p_halt_clear;
      halted |=> count_q == '0 && !runawayInterrupt;
   endproperty
   a_halt_clear: assert property (p_halt_clear)
      else $error("counter not cleared in halt mode");

   property p_bus_release;
      !busReleaseAck_n && !disabled_q && !halted && !lightIdleMode &&
      rstState_q == RWD_RST_IDLE |-> running;
   endproperty
   a_bus_release: assert property (p_bus_release)
      else $error("counter stopped during bus release");

   property p_light_idle;
      lightIdleMode && !mode_q[MODE_I2RUN] |=> $stable(count_q) || count_q == '0;
   endproperty
   a_light_idle: assert property (p_light_idle)
      else $error("counter moved in light idle without run bit");

   property p_reset_len;
      $rose(chipResetReq) |-> chipResetReq[*8] ##43 chipResetReq ##1 !chipResetReq;
   endproperty
   a_reset_len: assert property (p_reset_len)
      else $error("forced reset length wrong");

   property p_clear_code;
      wrCmd && wByte_q == CODE_CLEAR && !halted && !disabled_q |=> count_q == '0;
   endproperty
   a_clear_code: assert property (p_clear_code)
      else $error("clear code did not zero the counter");

   property p_disable;
      wrCmd && wByte_q == CODE_DISABLE && !mode_q[MODE_EN] |=> disabled_q;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable code ignored");

   property p_no_disable_when_set;
      !disabled_q && mode_q[MODE_EN] |=> !disabled_q;
   endproperty
   a_no_disable_when_set: assert property (p_no_disable_when_set)
      else $error("disabled while enable bit set");

   property p_reenable;
      wrMode && wByte_q[MODE_EN] |=> !disabled_q && mode_q[MODE_EN];
   endproperty
   a_reenable: assert property (p_reenable)
      else $error("enable bit did not re-enable");

   property p_other_code;
      wrCmd && wByte_q != CODE_CLEAR && wByte_q != CODE_DISABLE && !wrMode |=>
         $stable(disabled_q);
   endproperty
   a_other_code: assert property (p_other_code)
      else $error("stray command code changed enable state");

   c_expire:  cover property (expire);
   c_reset:   cover property ($fell(chipResetReq));
   c_disable: cover property ($rose(disabled_q));
   c_clear:   cover property (wrCmd && wByte_q == CODE_CLEAR && count_q != '0);

endmodule

// File: tb/rwd_runaway_watchdog_timer_tb_top.sv
/* bench for the runaway watchdog: drives axi4-lite and mode pins.
   assumes rwd_pkg register map, period select 0 for the long wait. */
`timescale 1ns/1ps
module rwd_runaway_watchdog_timer_tb_top;
   import rwd_pkg::*;
   // ************************************************************
   // signals
   // ************************************************************
   logic        ref_clk, rst_n;           // clock, async reset
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        deepIdleMode, stopMode, lightIdleMode, busReleaseAck_n;
   logic        runawayInterrupt, chipResetReq, irq;
   logic [31:0] rv, c1;                   // last read word, saved count
   int          miscompares, cmpCount;    // verdict counters
   rwd_runaway_watchdog_timer rwd_runaway_watchdog_timer_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .deepIdleMode(deepIdleMode), .stopMode(stopMode),
      .lightIdleMode(lightIdleMode), .busReleaseAck_n(busReleaseAck_n),
      .runawayInterrupt(runawayInterrupt), .chipResetReq(chipResetReq), .irq(irq));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic closeOut;
      $display("compares %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // a wait that ran out is a mismatch and ends the run
   task automatic tmo;
      miscompares++;
      closeOut;
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      rs = s_axi_bresp;
      if (n == 100) tmo;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      if (n == 100) tmo;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic testReset;
      rd(ADDR_MODE);
      chk(rv, {24'h0, MODE_RESET});
      rd(8'h14);
      chk({30'h0, rs}, 32'h2);                  // unmapped read refused
      wr(ADDR_COUNT, 32'h0);
      chk({30'h0, rs}, 32'h2);                  // read-only write refused
      rd(ADDR_COUNT);
      chk(rv != 32'h0, 32'h1);
      $display("reset test done");
   endtask
   task automatic testClear;
      wr(ADDR_CMD, {24'h0, CODE_CLEAR});
      chk({30'h0, rs}, 32'h0);                  // mapped write answers okay
      rd(ADDR_COUNT);
      c1 = rv;
      chk(c1 > 32'h0 && c1 < 32'h8, 32'h1);
      wr(ADDR_CMD, 32'h55);
      rd(ADDR_COUNT);
      chk(rv > c1 + 32'h4, 32'h1);
      busReleaseAck_n <= 1'h0;
      rd(ADDR_COUNT);
      c1 = rv;
      rd(ADDR_COUNT);
      chk(rv > c1, 32'h1);
      busReleaseAck_n <= 1'h1;
      $display("clear test done");
   endtask
   task automatic testIdle;
      for (int i = 0; i < 2; i++) begin
         deepIdleMode <= (i == 0);
         stopMode <= (i == 1);
         rd(ADDR_COUNT);
         rd(ADDR_COUNT);
         chk(rv, 32'h0);
      end
      deepIdleMode <= 1'h0;
      stopMode <= 1'h0;
      lightIdleMode <= 1'h1;
      rd(ADDR_COUNT);
      c1 = rv;
      rd(ADDR_COUNT);
      chk(rv, c1);
      lightIdleMode <= 1'h0;
      wr(ADDR_CMD, {24'h0, CODE_CLEAR});
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_CMD, {24'h0, CODE_DISABLE});
      wr(ADDR_MODE, 32'h88);                    // run bit before idle
      lightIdleMode <= 1'h1;
      rd(ADDR_COUNT);
      c1 = rv;
      rd(ADDR_COUNT);
      chk(rv > c1, 32'h1);
      lightIdleMode <= 1'h0;
      $display("idle test done");
   endtask
   task automatic testDisable;
      wr(ADDR_CMD, {24'h0, CODE_CLEAR});
      wr(ADDR_MODE, 32'h08);
      rd(ADDR_COUNT);
      chk(rv != 32'h0, 32'h1);
      wr(ADDR_CMD, {24'h0, CODE_DISABLE});
      rd(ADDR_COUNT);
      rd(ADDR_COUNT);
      chk(rv, 32'h0);
      wr(ADDR_MODE, 32'h6F);                    // enable stays low
      rd(ADDR_MODE);
      chk(rv, {24'h0, 8'h6F & MODE_MASK});      // period select stored
      rd(ADDR_COUNT);
      chk(rv, 32'h0);                           // still disabled
      wr(ADDR_MASK, 32'h3);
      wr(ADDR_MODE, 32'h84);
      $display("disable test done");
   endtask
   // hit of the shortest tap, forced reset length, sticky status
   task automatic testFire;
      int n;
      int h;
      for (n = 0; n < 70000 && !runawayInterrupt; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n == 70000) tmo;
      chk(n > 65520 && n < 65536, 32'h1);
      chk(chipResetReq, 32'h1);
      for (h = 0; h < 100 && chipResetReq; h++) begin
         @(posedge ref_clk);
         #1;
      end
      chk(h, {26'h0, RST_CYC});
      rd(ADDR_STAT);
      chk(rv, 32'h3);
      wr(ADDR_MASK, 32'h1);
      #1;
      chk(irq, 32'h1);                          // masked event line
      wr(ADDR_MASK, 32'h0);
      #1;
      chk(irq, 32'h0);                          // mask hides both
      wr(ADDR_STAT, 32'h3);
      rd(ADDR_STAT);
      chk(rv, 32'h0);                           // write one clears
      $display("fire test done");
   endtask
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {deepIdleMode, stopMode, lightIdleMode} = '0;
      s_axi_wstrb = 4'hF;
      busReleaseAck_n = 1'h1;
      rst_n = 1'h0;
      miscompares = 0;
      cmpCount = 0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'h1;
      testReset;
      testClear;
      testIdle;
      testDisable;
      testFire;
      closeOut;
   end
endmodule
